// *** acp_port.sv ***
// Control pins, register slave, serial shifter and output port of the dual converter
// Operation
// - In extended control, serial bits shift in and out with the serial clock.
// - Trigger low for a least time, then high a least time, runs calibration.
// - Trigger pin works in both modes; extended control ORs it with bit 15.
// - Sleep high powers a channel down; low restores it after a delay.
// - Extended control: sleep pin or control bit 11/10 powers the channel down.
// - Phase pin low gives 0-degree, high gives 90-degree strobe alignment.
// - Phase choice acts only in two-lane demultiplexed mode.
// - Extended control takes phase from bit 14, default 0-degree.
// - Outside extended control the span pin sets both channels low or high range.
// - Extended control takes I and Q spans from registers 3h and Bh.
// - Single-lane mode puts both early data buses into high impedance.
// - Two-lane mode: early buses carry the earlier sample of each pair.
// - Single-lane mode: late buses carry every sample at full rate.
// - Two-lane mode: late buses carry the sample one clock after the early one.
// - Overrange flag marks the data word presented with it.
// - Data is synchronous to the strobe; strobe rate follows lane mode.
// - I and Q strobes stay in phase unless a channel sleeps.
// - Extended control is active while the enable pin is low.
// - Single-lane pin high selects 1:1 mode, low selects 1:2 mode.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module acp_port
   import acp_pkg::*;
#(
   parameter int WAKE_CYC = WAKE_CYC_DEF, // Power-up delay after sleep ends
   parameter int CAL_LOW_CYC = CAL_LOW_CYC_DEF, // Least trigger low time
   parameter int CAL_HIGH_CYC = CAL_HIGH_CYC_DEF, // Least trigger high time
   parameter int CAL_RUN_CYC = CAL_RUN_CYC_DEF // Calibration length
) (
   input wire logic aclk, // Sampling clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state except cal_start, which clears while ce is low
   input wire logic [AXI_AW-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [AXI_AW-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic ext_ctl_enable_n, // Extended control enable, active low
   input wire logic single_lane_output_select, // High selects 1:1 output
   input wire logic strobe_phase_pin, // Strobe phase, high is 90 degrees
   input wire logic input_span_select, // Full-scale range pin
   input wire logic i_sleep, // I channel sleep pin
   input wire logic q_sleep, // Q channel sleep pin
   input wire logic cal_pin, // Calibration trigger pin
   input wire logic sclk, // Serial clock pin
   input wire logic scs_n, // Serial select, active low
   input wire logic sdi, // Serial data in
   output logic sdo, // Serial data out
   output logic sdo_oe, // Serial data out enable
   input wire logic [DATA_W-1:0] i_sample, // I converter word, every clock
   input wire logic i_sample_over, // I input beyond full scale
   input wire logic [DATA_W-1:0] q_sample, // Q converter word, every clock
   input wire logic q_sample_over, // Q input beyond full scale
   output logic [DATA_W-1:0] i_data_late, // I later sample bus
   output logic [DATA_W-1:0] i_data_early, // I earlier sample bus
   output logic i_early_oe, // I early bus drive enable
   output logic [DATA_W-1:0] q_data_late, // Q later sample bus
   output logic [DATA_W-1:0] q_data_early, // Q earlier sample bus
   output logic q_early_oe, // Q early bus drive enable
   output logic i_overrange, // I overrange flag
   output logic q_overrange, // Q overrange flag
   output logic i_output_strobe, // I data strobe
   output logic q_output_strobe, // Q data strobe
   output logic i_power_down, // I converter power-down
   output logic q_power_down, // Q converter power-down
   output logic [REG_W-1:0] i_span_code, // I full-scale range code
   output logic [REG_W-1:0] q_span_code, // Q full-scale range code
   output logic cal_start, // Calibration start pulse
   output logic cal_running // Calibration in progress
);
   localparam int WK_W = $clog2(WAKE_CYC + 1);
   localparam int NPIN = 10;
   if (WAKE_CYC < 1 || DATA_W != 10) begin : g_bad
      $error("acp_port needs WAKE_CYC of at least one and ten-bit data");
   end

   // Pin synchronisers
   logic [NPIN-1:0] pins_s;
   logic extended_control_mode, demux, ecm_n, lane_s, phase_s, span_s, isl_s, qsl_s, cal_s, sclk_s, scs_s, sdi_s;
   acp_sync #(.W(NPIN)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .async_in({ext_ctl_enable_n, single_lane_output_select, strobe_phase_pin,
                 input_span_select, i_sleep, q_sleep, cal_pin, sclk, scs_n, sdi}),
      .sync_out(pins_s)
   );
   assign {ecm_n, lane_s, phase_s, span_s, isl_s, qsl_s, cal_s, sclk_s, scs_s, sdi_s} = pins_s;
   assign extended_control_mode = ~ecm_n;
   assign demux = ~lane_s;

   // Registers and write channel
   logic [REG_W-1:0] ctrl_q, ctrl_d, ispan_q, ispan_d, qspan_q, qspan_d, wd_q, wd_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d;
   logic [IDX_W-1:0] awi_q, awi_d;
   logic [1:0] ws_q, ws_d, br_q, br_d;

   // Merge the two low byte lanes; upper lanes hit no storage
   function automatic logic [REG_W-1:0] lanes(input logic [REG_W-1:0] old,
                                               input logic [REG_W-1:0] wd,
                                               input logic [1:0] ws);
      lanes = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Address and data are held apart, so either may arrive first
   assign s_axi_awready = ce & ~aw_q & ~bv_q;
   assign s_axi_wready = ce & ~w_q & ~bv_q;
   always_comb begin
      aw_d = aw_q;
      awi_d = awi_q;
      w_d = w_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      ctrl_d = ctrl_q;
      ispan_d = ispan_q;
      qspan_d = qspan_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awi_d = s_axi_awaddr[AXI_AW-1:ADDR_LSB];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata[REG_W-1:0];
         ws_d = s_axi_wstrb[1:0];
      end
      if (ce && aw_q && w_q && !bv_q) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = RESP_OKAY;
         case (awi_q)
            IDX_CTRL: ctrl_d = lanes(ctrl_q, wd_q, ws_q);
            IDX_ISPAN: ispan_d = lanes(ispan_q, wd_q, ws_q);
            IDX_QSPAN: qspan_d = lanes(qspan_q, wd_q, ws_q);
            default: br_d = RESP_SLVERR; // Read-only or unmapped
         endcase
      end
      if (ce && bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RST;
         ispan_q <= SPAN_RST;
         qspan_q <= SPAN_RST;
         aw_q <= 1'b0;
         awi_q <= '0;
         w_q <= 1'b0;
         wd_q <= '0;
         ws_q <= '0;
         bv_q <= 1'b0;
         br_q <= RESP_OKAY;
      end else begin
         ctrl_q <= ctrl_d;
         ispan_q <= ispan_d;
         qspan_q <= qspan_d;
         aw_q <= aw_d;
         awi_q <= awi_d;
         w_q <= w_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
      end
   end
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;

   // Status word and read channel
   logic [1:0] pd_q, rdy_q, rr_q, rr_d;
   logic [REG_W-1:0] sr_q, stat;
   logic rv_q, rv_d;
   logic [31:0] rd_q, rd_d;
   always_comb begin
      stat = '0;
      stat[ST_CAL] = cal_running;
      stat[ST_IPD] = pd_q[0];
      stat[ST_QPD] = pd_q[1];
      stat[ST_IRDY] = rdy_q[0];
      stat[ST_QRDY] = rdy_q[1];
      stat[ST_ECM] = extended_control_mode;
      stat[ST_DEMUX] = demux;
   end
   assign s_axi_arready = ce & ~rv_q;
   always_comb begin
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (ce && rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = RESP_OKAY;
         rd_d = '0;
         case (s_axi_araddr[AXI_AW-1:ADDR_LSB])
            IDX_CTRL: rd_d[REG_W-1:0] = ctrl_q;
            IDX_ISPAN: rd_d[REG_W-1:0] = ispan_q;
            IDX_QSPAN: rd_d[REG_W-1:0] = qspan_q;
            IDX_STAT: rd_d[REG_W-1:0] = stat;
            IDX_SHIFT: rd_d[REG_W-1:0] = sr_q;
            default: rr_d = RESP_SLVERR;
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rv_q <= 1'b0;
         rd_q <= '0;
         rr_q <= RESP_OKAY;
      end else begin
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   // Serial shifter: in on the rising edge, out on the falling edge
   logic [REG_W-1:0] sr_d;
   logic sck_prev_q, sdo_q, sdo_d, soe_q, soe_d, sel;
   assign sel = extended_control_mode & ~scs_s;
   always_comb begin
      sr_d = sr_q;
      sdo_d = sdo_q;
      soe_d = sel;
      if (sel && sclk_s && !sck_prev_q) begin
         sr_d = {sr_q[REG_W-2:0], sdi_s};
      end
      if (sel && !sclk_s && sck_prev_q) begin
         sdo_d = sr_q[REG_W-1];
      end
   end
   // A parked low clock gives no edges, so nothing shifts between transfers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sr_q <= '0;
         sdo_q <= 1'b0;
         soe_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end else if (ce) begin
         sr_q <= sr_d;
         sdo_q <= sdo_d;
         soe_q <= soe_d;
         sck_prev_q <= sclk_s;
      end
   end
   assign sdo = sdo_q;
   assign sdo_oe = soe_q;

   // Calibration: pin alone, or pin ORed with the control bit
   acp_cal #(
      .LOW_CYC(CAL_LOW_CYC),
      .HIGH_CYC(CAL_HIGH_CYC),
      .RUN_CYC(CAL_RUN_CYC)
   ) u_cal (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .trig(cal_s | (extended_control_mode & ctrl_q[CTRL_CAL])),
      .cal_start(cal_start),
      .cal_running(cal_running)
   );

   // Shared pair position and strobe so both channels stay in step
   logic pair_q, pair_d, str_q, str_d, upd, ph90, mode_q, mode_d;
   assign ph90 = extended_control_mode ? ctrl_q[CTRL_PHASE] : phase_s;
   assign upd = ~demux | pair_q;
   always_comb begin
      mode_d = demux;
      pair_d = demux ? ~pair_q : 1'b1;
      if (!demux) begin
         str_d = ~str_q;
      end else if (pair_q ^ ph90) begin
         str_d = ~str_q;
      end else begin
         str_d = str_q;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pair_q <= 1'b0;
         str_q <= 1'b0;
         mode_q <= 1'b0;
      end else if (ce) begin
         pair_q <= pair_d;
         str_q <= str_d;
         mode_q <= mode_d;
      end
   end

   // Per-channel sleep, wake delay, sample pairing and output words
   logic [DATA_W-1:0] smp [2];
   logic [1:0] ovr;
   logic [1:0] slp;
   logic [DATA_W-1:0] late_q [2];
   logic [DATA_W-1:0] early_q [2];
   logic [1:0] or_q;
   logic [1:0] stb_q;
   logic [REG_W-1:0] span_q [2];
   assign smp[0] = i_sample;
   assign smp[1] = q_sample;
   assign ovr = {q_sample_over, i_sample_over};
   assign slp[0] = isl_s | (extended_control_mode & ctrl_q[CTRL_ISLEEP]);
   assign slp[1] = qsl_s | (extended_control_mode & ctrl_q[CTRL_QSLEEP]);
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [WK_W-1:0] wk_q;
      logic [WK_W-1:0] wk_d;
      logic rdy_d;
      logic [DATA_W-1:0] hold_q;
      logic [DATA_W-1:0] hold_d;
      logic hov_q;
      logic hov_d;
      logic [DATA_W-1:0] late_d;
      logic [DATA_W-1:0] early_d;
      logic or_d;
      logic stb_d;
      logic [REG_W-1:0] span_d;
      logic [REG_W-1:0] spreg;
      assign spreg = (c == 0) ? ispan_q : qspan_q;
      always_comb begin
         wk_d = wk_q;
         rdy_d = rdy_q[c];
         hold_d = hold_q;
         hov_d = hov_q;
         late_d = late_q[c];
         early_d = early_q[c];
         or_d = or_q[c];
         span_d = extended_control_mode ? spreg : (span_s ? SPAN_PIN_HI : SPAN_PIN_LO);
         if (slp[c]) begin
            wk_d = '0;
            rdy_d = 1'b0;
         end else if (!rdy_q[c]) begin
            if (wk_q >= WK_W'(WAKE_CYC - 1)) begin
               rdy_d = 1'b1;
            end else begin
               wk_d = WK_W'(wk_q + 1'b1);
            end
         end
         // Catch the first half of a pair even while waking
         if (!upd) begin
            hold_d = smp[c];
            hov_d = ovr[c];
         end
         if (!rdy_q[c]) begin
            late_d = '0; // Sleeping channel shows a quiet bus
            early_d = '0;
            or_d = 1'b0;
         end else if (upd) begin
            late_d = smp[c];
            early_d = hold_q;
            or_d = demux ? (ovr[c] | hov_q) : ovr[c];
         end
         stb_d = rdy_q[c] & str_d;
      end
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            wk_q <= '0;
            rdy_q[c] <= 1'b0;
            pd_q[c] <= 1'b0;
            hold_q <= '0;
            hov_q <= 1'b0;
            late_q[c] <= '0;
            early_q[c] <= '0;
            or_q[c] <= 1'b0;
            stb_q[c] <= 1'b0;
            span_q[c] <= SPAN_PIN_LO;
         end else if (ce) begin
            wk_q <= wk_d;
            rdy_q[c] <= rdy_d;
            pd_q[c] <= slp[c];
            hold_q <= hold_d;
            hov_q <= hov_d;
            late_q[c] <= late_d;
            early_q[c] <= early_d;
            or_q[c] <= or_d;
            stb_q[c] <= stb_d;
            span_q[c] <= span_d;
         end
      end
   end

   // Output mapping; early buses float in single-lane mode
   assign i_data_late = late_q[0];
   assign q_data_late = late_q[1];
   assign i_data_early = early_q[0];
   assign q_data_early = early_q[1];
   assign i_early_oe = mode_q;
   assign q_early_oe = mode_q;
   assign i_overrange = or_q[0];
   assign q_overrange = or_q[1];
   assign i_output_strobe = stb_q[0];
   assign q_output_strobe = stb_q[1];
   assign i_power_down = pd_q[0];
   assign q_power_down = pd_q[1];
   assign i_span_code = span_q[0];
   assign q_span_code = span_q[1];
endmodule // acp_port

// *** acp_pkg.sv ***
// Shared constants and types of the converter control and output port block
package acp_pkg;
   // Widths
   localparam int DATA_W = 10;
   localparam int REG_W = 16;
   localparam int AXI_AW = 7;
   localparam int ADDR_LSB = 2;
   localparam int IDX_W = AXI_AW - ADDR_LSB;
   // Register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL = 5'h00;
   localparam logic [IDX_W-1:0] IDX_ISPAN = 5'h03;
   localparam logic [IDX_W-1:0] IDX_QSPAN = 5'h0b;
   localparam logic [IDX_W-1:0] IDX_STAT = 5'h10;
   localparam logic [IDX_W-1:0] IDX_SHIFT = 5'h11;
   // Control register fields
   localparam int CTRL_CAL = 15;
   localparam int CTRL_PHASE = 14;
   localparam int CTRL_ISLEEP = 11;
   localparam int CTRL_QSLEEP = 10;
   // Reset values and span codes used outside extended control
   localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
   localparam logic [REG_W-1:0] SPAN_RST = 16'h4000;
   localparam logic [REG_W-1:0] SPAN_PIN_LO = 16'h0000;
   localparam logic [REG_W-1:0] SPAN_PIN_HI = 16'h4000;
   // Status register fields
   localparam int ST_CAL = 0;
   localparam int ST_IPD = 1;
   localparam int ST_QPD = 2;
   localparam int ST_IRDY = 3;
   localparam int ST_QRDY = 4;
   localparam int ST_ECM = 5;
   localparam int ST_DEMUX = 6;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing, in ns, and cycle counts at the 5 ns clock
   localparam int CLK_PS = 5000;
   localparam int CAL_LOW_NS = 80;
   localparam int CAL_HIGH_NS = 80;
   localparam int CAL_RUN_NS = 1000;
   localparam int WAKE_NS = 500;
   localparam int CAL_LOW_CYC_DEF = (CAL_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CAL_HIGH_CYC_DEF = (CAL_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int CAL_RUN_CYC_DEF = (CAL_RUN_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WAKE_CYC_DEF = (WAKE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   // Calibration trigger states
   typedef enum logic [3:0] {
      CAL_IDLE = 4'h1,
      CAL_LOWOK = 4'h2,
      CAL_HIGH = 4'h4,
      CAL_RUN = 4'h8
   } acp_cal_state_t;
endpackage

// *** acp_sync.sv ***
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module acp_sync #(
   parameter int W = 1 // Number of levels
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic [W-1:0] async_in, // Outside levels
   output logic [W-1:0] sync_out // Synchronised levels
);
   if (W < 1) begin : g_bad
      $error("acp_sync needs at least one bit");
   end
   // One pair of flops per bit; the first flop feeds only the second
   for (genvar b = 0; b < W; b++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic out_q;
      logic out_d;
      always_comb begin
         meta_d = ce ? async_in[b] : meta_q;
         out_d = ce ? meta_q : out_q;
      end
      always_ff @(posedge aclk) begin
         meta_q <= aresetn ? meta_d : 1'b0;
         out_q <= aresetn ? out_d : 1'b0;
      end
      assign sync_out[b] = out_q;
   end
endmodule // acp_sync

// *** acp_cal.sv ***
// Calibration trigger qualifier and calibration run timer
`timescale 1ns/1ps
module acp_cal
   import acp_pkg::*;
#(
   parameter int LOW_CYC = CAL_LOW_CYC_DEF, // Least low time of the trigger
   parameter int HIGH_CYC = CAL_HIGH_CYC_DEF, // Least high time of the trigger
   parameter int RUN_CYC = CAL_RUN_CYC_DEF // Length of one calibration
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic trig, // Combined trigger level
   output logic cal_start, // One-cycle pulse as calibration begins
   output logic cal_running // High while calibration runs
);
   localparam int MAXC = (RUN_CYC > LOW_CYC) ? RUN_CYC : LOW_CYC;
   localparam int CW = $clog2(MAXC + HIGH_CYC + 1);
   if (LOW_CYC < 1 || HIGH_CYC < 1 || RUN_CYC < 1) begin : g_bad
      $error("acp_cal counts must be at least one");
   end
   acp_cal_state_t st_q;
   acp_cal_state_t st_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic start_q;
   logic start_d;
   // Low must last first, then high; a trigger held high from reset never fires
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      start_d = 1'b0;
      if (ce) begin
         unique case (st_q)
            CAL_IDLE: begin
               if (trig) begin
                  cnt_d = '0;
               end else if (cnt_q >= CW'(LOW_CYC - 1)) begin
                  st_d = CAL_LOWOK;
               end else begin
                  cnt_d = CW'(cnt_q + 1'b1);
               end
            end
            CAL_LOWOK: begin
               if (trig) begin
                  st_d = CAL_HIGH;
                  cnt_d = CW'(1);
               end
            end
            CAL_HIGH: begin
               if (!trig) begin
                  st_d = CAL_IDLE; // Too short a high: start again
                  cnt_d = CW'(1);
               end else if (cnt_q >= CW'(HIGH_CYC)) begin
                  st_d = CAL_RUN;
                  cnt_d = '0;
                  start_d = 1'b1;
               end else begin
                  cnt_d = CW'(cnt_q + 1'b1);
               end
            end
            CAL_RUN: begin
               if (cnt_q >= CW'(RUN_CYC - 1)) begin
                  st_d = CAL_IDLE; // One cycle per request
                  cnt_d = '0;
               end else begin
                  cnt_d = CW'(cnt_q + 1'b1);
               end
            end
            default: begin
               st_d = CAL_IDLE;
               cnt_d = '0;
            end
         endcase
      end
   end
   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= CAL_IDLE;
         cnt_q <= '0;
         start_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         start_q <= start_d;
      end
   end
   assign cal_start = start_q;
   assign cal_running = (st_q == CAL_RUN);
endmodule // acp_cal

// *** acp_port_monitor.sv ***
// Port checker bound to acp_port
`timescale 1ns/1ps
module acp_port_monitor (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic single_lane_output_select, // Lane pin
   input wire logic i_early_oe, // Early drive
   input wire logic cal_start, // Cal pulse
   input wire logic cal_running, // Cal busy
   input wire logic i_power_down, // I down
   input wire logic q_power_down, // Q down
   input wire logic i_output_strobe, // I strobe
   input wire logic q_output_strobe, // Q strobe
   input wire logic i_sleep, // I sleep
   input wire logic [9:0] i_sample, // I word
   input wire logic i_sample_over, // I flag in
   input wire logic i_overrange, // I flag out
   input wire logic [9:0] i_data_late, // Late bus
   input wire logic [9:0] i_data_early // Early bus
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // I awake in 1:1 mode
   logic one_up;
   assign one_up = single_lane_output_select & ~i_power_down;
   // Pins pass two sync flops, so each window outlasts that lag
   a_early_float: assert property ($stable(single_lane_output_select)[*4]
      |-> i_early_oe == !single_lane_output_select) else $error("early drive");
   a_cal_pulse: assert property (cal_start |-> cal_running ##1 !cal_start)
      else $error("cal pulse");
   a_cal_length: assert property ($rose(cal_running) |-> cal_running[*8] ##1 !cal_running)
      else $error("cal length");
   a_sleep_down: assert property (i_sleep[*4] |-> i_power_down) else $error("sleep");
   a_strobe_phase: assert property ((!i_power_down && !q_power_down)[*8]
      |-> i_output_strobe == q_output_strobe) else $error("strobe phase");
   a_full_rate: assert property (one_up[*8] |-> $changed(i_output_strobe))
      else $error("strobe rate");
   a_late_word: assert property (one_up[*8] |-> i_data_late == $past(i_sample))
      else $error("late word");
   a_over_flag: assert property (one_up[*8] |-> i_overrange == $past(i_sample_over))
      else $error("overrange");
   a_pair_order: assert property ((!single_lane_output_select && !i_power_down)[*8]
      ##0 $changed(i_data_late) |-> i_data_early == $past(i_sample, 2)
      && i_data_late == $past(i_sample)) else $error("pair order");
   c_cal: cover property (cal_start);
   c_single: cover property (single_lane_output_select && i_output_strobe);
   c_i_down: cover property (i_power_down && !q_power_down);
endmodule // acp_port_monitor
bind acp_port acp_port_monitor u_mon (.*);

// *** acp_ctl_model.sv ***
// Serial controller model driving the link pins
`timescale 1ns/1ps
module acp_ctl_model (
   output logic sclk, // Serial clock
   output logic scs_n, // Select, active low
   output logic sdi // Serial data
);
   initial {sclk, scs_n, sdi} = 3'b010;
   // One frame MSB first; sclk parks low outside frames
   task frame(input logic [15:0] w);
      #1 scs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 scs_n = 1'b1;
      sdi = !sdi; // Released line keeps no stale value
   endtask
endmodule // acp_ctl_model

// *** tb_acp_port.sv ***
// Self-checking bench of the converter port
`timescale 1ns/1ps
module tb_acp_port;
   import acp_pkg::*;
`define CHK(a,e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
   logic aclk=0, aresetn=0, ce=1, ext_ctl_enable_n=1, single_lane_output_select=0, cal_pin=0;
   logic strobe_phase_pin=0, input_span_select=0, i_sleep=0, q_sleep=0, sdo, sdo_oe, sclk, scs_n;
   logic s_axi_awvalid=0, s_axi_wvalid=0, s_axi_arvalid=0, s_axi_bready=1, s_axi_rready=1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sdi;
   logic [6:0] s_axi_awaddr=0, s_axi_araddr=0;
   logic [31:0] s_axi_wdata=0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb=4'h3;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [9:0] i_sample=0, q_sample=0, i_data_late, i_data_early, q_data_late, q_data_early;
   logic i_sample_over=0, q_sample_over=0, i_early_oe, q_early_oe, i_overrange, q_overrange;
   logic i_output_strobe, q_output_strobe, i_power_down, q_power_down, cal_start, cal_running;
   logic [15:0] i_span_code, q_span_code;
   logic [33:0] rows [4] = '{34'h2_0000_0000, 34'h3_4000_4000, 34'h1_1234_0abc, 34'h0_1234_0abc};
   int error_cnt=0, checked=0, cyc=0;
   initial forever #2.5 aclk = !aclk;
   acp_port #(.WAKE_CYC(4), .CAL_LOW_CYC(2), .CAL_HIGH_CYC(2), .CAL_RUN_CYC(8)) DUT (.*);
   acp_ctl_model P (.sclk, .scs_n, .sdi);
   // Sample ramp; also the hang limit
   always @(posedge aclk) begin
      {i_sample, q_sample} <= {i_sample + 10'h001, i_sample};
      {i_sample_over, q_sample_over} <= i_sample[3:2];
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   // Ready is read mid-cycle, where it holds until the next edge
   task bus(input bit w, input logic [6:0] a, input logic [31:0] wd);
      logic [3:0] t;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
      do begin
         @(negedge aclk);
         t = {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid | s_axi_rvalid};
         {d, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
         @(posedge aclk);
         if (t[3]) s_axi_awvalid <= 1'b0;
         if (t[2]) s_axi_wvalid <= 1'b0;
         if (t[1]) s_axi_arvalid <= 1'b0;
      end while (!t[0]);
   endtask
   task calwait;
      for (int k = 0; k < 40 && cal_start !== 1'b1; k++) @(negedge aclk);
      `CHK(cal_running, 1'b1)
      @(posedge aclk);
   endtask
   // 0-degree strobe toggles with the data, 90-degree one edge later
   task phase_chk(input bit ninety);
      logic [10:0] p;
      repeat (9) @(negedge aclk);
      p = {i_output_strobe, i_data_late};
      repeat (8) begin
         @(negedge aclk);
         if (i_data_late !== p[9:0]) `CHK(i_output_strobe !== p[10], !ninety)
         p = {i_output_strobe, i_data_late};
      end
      @(posedge aclk);
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      bus(1'b0, 7'h0c, 32'h0);
      `CHK(d, 32'h4000)
      bus(1'b0, 7'h7c, 32'h0);
      `CHK(r, RESP_SLVERR)
      bus(1'b1, 7'h0c, 32'h1234);
      `CHK(r, RESP_OKAY)
      bus(1'b1, 7'h2c, 32'h0abc);
      foreach (rows[k]) begin
         {ext_ctl_enable_n, input_span_select} <= rows[k][33:32];
         repeat (6) @(negedge aclk);
         `CHK({i_span_code, q_span_code}, rows[k][31:0])
         @(posedge aclk);
      end
      P.frame(16'ha5c3);
      @(posedge aclk);
      bus(1'b0, 7'h44, 32'h0);
      `CHK(d, 32'h0000a5c3)
      bus(1'b1, 7'h00, 32'h0800);
      repeat (3) @(negedge aclk);
      `CHK({i_power_down, q_power_down}, 2'b10)
      @(posedge aclk);
      bus(1'b1, 7'h00, 32'h8000);
      calwait;
      strobe_phase_pin <= 1'b1;
      phase_chk(1'b0);
      ext_ctl_enable_n <= 1'b1;
      phase_chk(1'b1);
      cal_pin <= 1'b1;
      calwait;
      {cal_pin, i_sleep} <= 2'b01;
      repeat (5) @(negedge aclk);
      `CHK(i_power_down, 1'b1)
      @(posedge aclk);
      {i_sleep, single_lane_output_select} <= 2'b01;
      repeat (20) @(negedge aclk);
      `CHK({i_early_oe, q_early_oe}, 2'b00)
      report_and_stop;
   end
endmodule // tb_acp_port
